// [logic/dmarpt_pkg.sv]
// Constants, register map and state type for the repeating DMA channel
// Functional notes
// - Clear mask set keeps channel enable after end
// - Repeat completion clears pause, trigger; waits again
// - Success writes done code into stop status
// - Reload bits restore counts and addresses
// - No success interrupt while done enable clear
// - Bus error keeps enable, returns to wait
// - Peripheral stop reloads, waits, raises failure interrupt
// - Wait return leaves enables set, halt zero
// - Next peripheral request starts without CPU
// - Requests ignored after peripheral stop until CPU
// - Clearing stop status drops interrupt; then disable
// - Clear mask zero ends into disable cleanly
// - Channel disable clears enable; global keeps it
// - Forced exit from transfer raises failure interrupt
// - Peripheral stop interrupt held until CPU clears
// - Software stop interrupt held until CPU clears
// - Re-entering transfer withdraws other completion interrupts
// - Peripheral stop writes software stop code
// - Nonzero global halt pauses, zero resumes
package dmarpt_pkg;
   localparam int          ADDR_W       = 5;
   localparam int          DATA_W       = 32;
   localparam logic [4:0]  OFS_GLOBAL   = 5'h00;
   localparam logic [4:0]  OFS_CFG_A    = 5'h04;
   localparam logic [4:0]  OFS_CFG_B    = 5'h08;
   localparam logic [4:0]  OFS_SRC      = 5'h0c;
   localparam logic [4:0]  OFS_DST      = 5'h10;
   localparam logic [4:0]  OFS_STATUS   = 5'h14;
   localparam int          GE_BIT       = 31;
   localparam int          GH_LSB       = 24;
   localparam int          GH_W         = 4;
   localparam int          CE_BIT       = 31;
   localparam int          CP_BIT       = 30;
   localparam int          ST_BIT       = 29;
   localparam int          BC_LSB       = 16;
   localparam int          BC_W         = 8;
   localparam int          TC_LSB       = 0;
   localparam int          TC_W         = 16;
   localparam int          EM_BIT       = 0;
   localparam int          DIE_BIT      = 1;
   localparam int          EIE_BIT      = 2;
   localparam int          RC_BIT       = 3;
   localparam int          RS_BIT       = 4;
   localparam int          RD_BIT       = 5;
   localparam int          SS_LSB       = 16;
   localparam int          SS_W         = 3;
   localparam logic [2:0]  SS_NONE      = 3'h0;
   localparam logic [2:0]  SS_ERR       = 3'h1;
   localparam logic [2:0]  SS_STOP      = 3'h2;
   localparam logic [2:0]  SS_DONE      = 3'h5;
   localparam logic [3:0]  GH_RUN       = 4'h0;
   localparam logic [31:0] ADDR_STEP    = 32'h4;
   localparam logic [31:0] ZERO_W       = 32'h0;
   typedef enum logic [1:0] {DR_DISABLE, DR_WAIT, DR_XFER, DR_PAUSE} dmarpt_state_t;
endpackage : dmarpt_pkg

// [logic/dmarpt_channel.sv]
// Single DMA channel with repeat mode, register port and peripheral request lines
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module dmarpt_channel
   import dmarpt_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   input  wire logic              per_req,
   input  wire logic              per_stop,
   input  wire logic              bus_err,
   output logic                   xfer_strobe,
   output logic      [31:0]       xfer_src,
   output logic      [31:0]       xfer_dst,
   output logic                   per_ack,
   output logic                   irq,
   output dmarpt_state_t          chan_state
);
   // Programmed and working state
   dmarpt_state_t     state_reg;
   logic              ge_reg, ce_reg, cp_reg, st_reg;
   logic [GH_W-1:0]   gh_reg;
   logic              em_reg, die_reg, eie_reg, rc_reg, rs_reg, rd_reg;
   logic [SS_W-1:0]   ss_reg;
   logic [BC_W-1:0]   bc_prog_reg, bc_reg;
   logic [TC_W-1:0]   tc_prog_reg, tc_reg;
   logic [31:0]       src_prog_reg, src_reg, dst_prog_reg, dst_reg;
   logic              irq_reg, irq_hold_reg, pstop_hold_reg, ack_hold_reg;
   logic              req_m_reg, req_s_reg, stop_m_reg, stop_s_reg;
   logic              strobe_reg, ack_reg;
   logic [DATA_W-1:0] rdata_reg;

   // Register decode
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   logic wr_g, wr_a, wr_b, wr_s, wr_d, ss_clr, active, running, req_eff, last, ev_end;
   logic ev_start, ev_issue, ev_resp, ev_err, ev_done, ev_pstop, ev_force, ev_cancel, ev_pause, ev_resume, ev_arm;

   assign wr_g   = ce && reg_wr && hit(reg_addr, OFS_GLOBAL);
   assign wr_a   = ce && reg_wr && hit(reg_addr, OFS_CFG_A);
   assign wr_b   = ce && reg_wr && hit(reg_addr, OFS_CFG_B);
   assign wr_s   = ce && reg_wr && hit(reg_addr, OFS_SRC);
   assign wr_d   = ce && reg_wr && hit(reg_addr, OFS_DST);
   assign ss_clr = wr_b && (reg_wdata[SS_LSB +: SS_W] == SS_NONE);

   // Channel event decode
   assign running   = ge_reg && ce_reg && (gh_reg == GH_RUN) && !cp_reg;
   assign active    = (state_reg == DR_XFER) || (state_reg == DR_PAUSE);
   assign req_eff   = req_s_reg && !stop_s_reg && !ack_hold_reg;
   assign last      = (tc_reg == '0) && (bc_reg == '0);
   assign ev_force  = ce && active && (!ge_reg || !ce_reg);
   assign ev_cancel = ce && (state_reg == DR_WAIT) && !running;
   assign ev_arm    = ce && (state_reg == DR_DISABLE) && running;
   assign ev_start  = ce && (state_reg == DR_WAIT) && running && req_eff && !pstop_hold_reg;
   assign ev_resp   = ce && (state_reg == DR_XFER) && strobe_reg && !ev_force;
   assign ev_err    = ev_resp && bus_err;
   assign ev_done   = ev_resp && !bus_err && last;
   assign ev_pstop  = ce && (state_reg == DR_XFER) && !strobe_reg && !ev_force && stop_s_reg;
   assign ev_pause  = ce && (state_reg == DR_XFER) && !strobe_reg && !ev_force && !stop_s_reg
                      && ((gh_reg != GH_RUN) || cp_reg);
   assign ev_resume = ce && (state_reg == DR_PAUSE) && !ev_force && (gh_reg == GH_RUN) && !cp_reg;
   assign ev_issue  = ce && (state_reg == DR_XFER) && !strobe_reg && !ev_force && !ev_pstop && !ev_pause
                      && req_eff;
   assign ev_end    = ev_done || ev_err || ev_pstop;

   // Two-stage synchronisers for peripheral lines
   always_ff @(posedge clk) begin
      if (!resetn) begin
         req_m_reg  <= 1'b0;
         req_s_reg  <= 1'b0;
         stop_m_reg <= 1'b0;
         stop_s_reg <= 1'b0;
      end else if (ce) begin
         req_m_reg  <= per_req;
         req_s_reg  <= req_m_reg;
         stop_m_reg <= per_stop;
         stop_s_reg <= stop_m_reg;
      end
   end

   // Channel state machine
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_reg <= DR_DISABLE;
      end else if (ce) begin
         unique case (state_reg)
            DR_DISABLE: if (ev_arm) state_reg <= DR_WAIT;
            DR_WAIT: begin
               if (ev_cancel) state_reg <= DR_DISABLE;
               else if (ev_start) state_reg <= DR_XFER;
            end
            DR_XFER: begin
               if (ev_force) state_reg <= DR_DISABLE;
               else if (ev_end) state_reg <= em_reg ? DR_WAIT : DR_DISABLE;
               else if (ev_pause) state_reg <= DR_PAUSE;
            end
            DR_PAUSE: begin
               if (ev_force) state_reg <= DR_DISABLE;
               else if (ev_resume) state_reg <= DR_XFER;
            end
         endcase
      end
   end

   // Global and channel control bits
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ge_reg <= 1'b0;
         gh_reg <= GH_RUN;
         ce_reg <= 1'b0;
         cp_reg <= 1'b0;
         st_reg <= 1'b0;
         {em_reg, die_reg, eie_reg, rc_reg, rs_reg, rd_reg} <= '0;
      end else if (ce) begin
         if (wr_g) begin
            ge_reg <= reg_wdata[GE_BIT];
            gh_reg <= reg_wdata[GH_LSB +: GH_W];
         end
         if (wr_b) begin
            em_reg  <= reg_wdata[EM_BIT];
            die_reg <= reg_wdata[DIE_BIT];
            eie_reg <= reg_wdata[EIE_BIT];
            rc_reg  <= reg_wdata[RC_BIT];
            rs_reg  <= reg_wdata[RS_BIT];
            rd_reg  <= reg_wdata[RD_BIT];
         end
         if (ev_end) begin
            cp_reg <= 1'b0;
            st_reg <= 1'b0;
            ce_reg <= em_reg;
         end else if (wr_a) begin
            ce_reg <= reg_wdata[CE_BIT];
            cp_reg <= reg_wdata[CP_BIT];
            st_reg <= reg_wdata[ST_BIT];
         end
      end
   end

   // Counts and addresses: programmed copies and working values
   always_ff @(posedge clk) begin
      if (!resetn) begin
         bc_prog_reg <= '0;
         bc_reg      <= '0;
         tc_prog_reg <= '0;
         tc_reg      <= '0;
         src_prog_reg <= ZERO_W;
         src_reg      <= ZERO_W;
         dst_prog_reg <= ZERO_W;
         dst_reg      <= ZERO_W;
      end else if (ce) begin
         if (ev_done || ev_pstop) begin
            if (rc_reg) begin
               bc_reg <= bc_prog_reg;
               tc_reg <= tc_prog_reg;
            end
            if (rs_reg) src_reg <= src_prog_reg;
            if (rd_reg) dst_reg <= dst_prog_reg;
         end else if (ev_resp && !bus_err) begin
            src_reg <= src_reg + ADDR_STEP;
            dst_reg <= dst_reg + ADDR_STEP;
            if (tc_reg == '0) begin
               tc_reg <= tc_prog_reg;
               bc_reg <= bc_reg - 1'b1;
            end else begin
               tc_reg <= tc_reg - 1'b1;
            end
         end else begin
            if (wr_a) begin
               bc_prog_reg <= reg_wdata[BC_LSB +: BC_W];
               bc_reg      <= reg_wdata[BC_LSB +: BC_W];
               tc_prog_reg <= reg_wdata[TC_LSB +: TC_W];
               tc_reg      <= reg_wdata[TC_LSB +: TC_W];
            end
            if (wr_s) begin
               src_prog_reg <= reg_wdata;
               src_reg      <= reg_wdata;
            end
            if (wr_d) begin
               dst_prog_reg <= reg_wdata;
               dst_reg      <= reg_wdata;
            end
         end
      end
   end

   // Status, irq, request masks; an acknowledged request is ignored until it falls, so its echo never restarts
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ss_reg         <= SS_NONE;
         irq_reg        <= 1'b0;
         irq_hold_reg   <= 1'b0;
         {pstop_hold_reg, ack_hold_reg} <= 2'h0;
      end else if (ce) begin
         ack_hold_reg <= ev_done || (ack_hold_reg && req_s_reg);
         if (ev_done) ss_reg <= SS_DONE;
         else if (ev_pstop || ev_force) ss_reg <= SS_STOP;
         else if (ev_err) ss_reg <= SS_ERR;
         else if (ss_clr) ss_reg <= SS_NONE;
         if (ev_pstop) pstop_hold_reg <= 1'b1;
         else if (ss_clr) pstop_hold_reg <= 1'b0;
         if ((ev_done && die_reg) || ((ev_err || ev_pstop || ev_force) && eie_reg)) begin
            irq_reg      <= 1'b1;
            irq_hold_reg <= ev_pstop || ev_force;
         end else if (ss_clr || (ev_start && !irq_hold_reg)) begin
            irq_reg      <= 1'b0;
            irq_hold_reg <= 1'b0;
         end
      end
   end

   // Transfer strobe, addresses and peripheral acknowledge
   always_ff @(posedge clk) begin
      if (!resetn) begin
         strobe_reg <= 1'b0;
         ack_reg    <= 1'b0;
         xfer_src   <= ZERO_W;
         xfer_dst   <= ZERO_W;
      end else if (ce) begin
         strobe_reg <= ev_issue;
         ack_reg    <= ev_done;
         if (ev_issue) begin
            xfer_src <= src_reg;
            xfer_dst <= dst_reg;
         end
      end
   end

   // Read data, valid the cycle after the read strobe
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_reg <= ZERO_W;
      end else if (ce) begin
         rdata_reg <= ZERO_W;
         if (reg_rd) begin
            if (hit(reg_addr, OFS_GLOBAL)) begin
               rdata_reg[GE_BIT]          <= ge_reg;
               rdata_reg[GH_LSB +: GH_W]  <= gh_reg;
            end else if (hit(reg_addr, OFS_CFG_A)) begin
               rdata_reg[CE_BIT]          <= ce_reg;
               rdata_reg[CP_BIT]          <= cp_reg;
               rdata_reg[ST_BIT]          <= st_reg;
               rdata_reg[BC_LSB +: BC_W]  <= bc_reg;
               rdata_reg[TC_LSB +: TC_W]  <= tc_reg;
            end else if (hit(reg_addr, OFS_CFG_B)) begin
               rdata_reg[EM_BIT]          <= em_reg;
               rdata_reg[DIE_BIT]         <= die_reg;
               rdata_reg[EIE_BIT]         <= eie_reg;
               rdata_reg[RC_BIT]          <= rc_reg;
               rdata_reg[RS_BIT]          <= rs_reg;
               rdata_reg[RD_BIT]          <= rd_reg;
               rdata_reg[SS_LSB +: SS_W]  <= ss_reg;
            end else if (hit(reg_addr, OFS_SRC)) begin
               rdata_reg <= src_reg;
            end else if (hit(reg_addr, OFS_DST)) begin
               rdata_reg <= dst_reg;
            end else if (hit(reg_addr, OFS_STATUS)) begin
               rdata_reg[1:0] <= state_reg;
               rdata_reg[2]   <= pstop_hold_reg;
               rdata_reg[3]   <= irq_hold_reg;
            end
         end
      end
   end

   assign reg_rdata   = rdata_reg;
   assign xfer_strobe = strobe_reg;
   assign per_ack     = ack_reg;
   assign irq         = irq_reg;
   assign chan_state  = state_reg;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_back_in_wait;
      (state_reg == DR_WAIT) && ce_reg && !cp_reg && !st_reg;
   endsequence
   sequence s_reloaded;
      (tc_reg == tc_prog_reg) && (bc_reg == bc_prog_reg);
   endsequence

   property p_repeat_done;
      ev_done && em_reg |=> s_back_in_wait and (ss_reg == SS_DONE);
   endproperty
   a_repeat_done: assert property (p_repeat_done) else $error("repeat completion did not rearm");
   property p_reload;
      ev_done && rc_reg |=> s_reloaded;
   endproperty
   a_reload: assert property (p_reload) else $error("counts not reloaded");
   property p_no_done_irq;
      ev_done && !die_reg && !irq_reg |=> !irq_reg;
   endproperty
   a_no_done_irq: assert property (p_no_done_irq) else $error("success irq without enable");
   property p_err_rearm;
      ev_err && em_reg |=> s_back_in_wait ##0 (ss_reg == SS_ERR);
   endproperty
   a_err_rearm: assert property (p_err_rearm) else $error("error end did not rearm");
   property p_pstop;
      ev_pstop && em_reg && eie_reg |=> s_back_in_wait ##0 (irq_reg && ss_reg == SS_STOP) ##0 s_reloaded
         or !rc_reg;
   endproperty
   a_pstop: assert property (p_pstop) else $error("peripheral stop handling wrong");
   property p_start;
      ev_start |=> (state_reg == DR_XFER) ##1 (state_reg != DR_WAIT);
   endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_masked;
      ce && (state_reg == DR_WAIT) && (stop_s_reg || pstop_hold_reg) |=> state_reg != DR_XFER;
   endproperty
   a_masked: assert property (p_masked) else $error("request taken while masked");
   property p_clear_drops_irq;
      ss_clr && !ev_end && !ev_force |=> !irq_reg && (ss_reg == SS_NONE);
   endproperty
   a_clear_drops_irq: assert property (p_clear_drops_irq) else $error("irq kept after status clear");
   property p_em_zero;
      ev_done && !em_reg |=> (state_reg == DR_DISABLE) && !ce_reg && !cp_reg && !st_reg;
   endproperty
   a_em_zero: assert property (p_em_zero) else $error("single completion not disabling");
   property p_force;
      ev_force && eie_reg |=> (state_reg == DR_DISABLE) && irq_reg && irq_hold_reg;
   endproperty
   a_force: assert property (p_force) else $error("forced exit irq missing");
   property p_hold;
      ce && irq_hold_reg && irq_reg && !ss_clr |=> irq_reg;
   endproperty
   a_hold: assert property (p_hold) else $error("held stop irq dropped");
   property p_halt;
      ev_pause |=> (state_reg == DR_PAUSE) && !xfer_strobe;
   endproperty
   a_halt: assert property (p_halt) else $error("halt did not pause");
endmodule : dmarpt_channel
`default_nettype wire

// [dv/dmarpt_periph_model.sv]
// Peripheral model driving transfer request, stop request and bus error
`timescale 1ns/10ps
`default_nettype none
module dmarpt_periph_model (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic req_set,
   input  wire logic req_clr,
   input  wire logic stop_set,
   input  wire logic err_arm,
   input  wire logic xfer_strobe,
   input  wire logic per_ack,
   output logic      per_req,
   output logic      per_stop,
   output logic      bus_err
);
   logic per_req_reg;
   // Request level held until acknowledged or withdrawn on CPU instruction
   always_ff @(posedge clk) begin
      if (!resetn) begin
         per_req_reg <= 1'b0;
      end else if (per_ack || req_clr) begin
         per_req_reg <= 1'b0;
      end else if (req_set) begin
         per_req_reg <= 1'b1;
      end
   end
   // Stop level follows the bench; error answered in the beat's own cycle
   assign per_req  = per_req_reg;
   assign per_stop = stop_set;
   assign bus_err  = xfer_strobe & err_arm;
endmodule : dmarpt_periph_model
`default_nettype wire

// [dv/tb_dma_channel_repeat_hw_transfer.sv]
// Self-checking bench for the repeating DMA channel
`timescale 1ns/10ps
`default_nettype none
module tb_dma_channel_repeat_hw_transfer;
   import dmarpt_pkg::*;
   localparam logic [31:0] FULL = 32'hffffffff;
   logic                clk, resetn, ce, reg_wr, reg_rd, per_req, per_stop, bus_err;
   logic                xfer_strobe, per_ack, irq, req_set, req_clr, stop_set, err_arm;
   logic [ADDR_W-1:0]   reg_addr;
   logic [DATA_W-1:0]   reg_wdata, reg_rdata;
   logic [31:0]         xfer_src, xfer_dst;
   dmarpt_state_t       chan_state;
   int                  fail_count, cmp_count, nb;

   dmarpt_channel dut (.clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .per_req(per_req), .per_stop(per_stop),
      .bus_err(bus_err), .xfer_strobe(xfer_strobe), .xfer_src(xfer_src), .xfer_dst(xfer_dst),
      .per_ack(per_ack), .irq(irq), .chan_state(chan_state));
   dmarpt_periph_model periph (.clk(clk), .resetn(resetn), .req_set(req_set), .req_clr(req_clr),
      .stop_set(stop_set), .err_arm(err_arm), .xfer_strobe(xfer_strobe), .per_ack(per_ack),
      .per_req(per_req), .per_stop(per_stop), .bus_err(bus_err));

   // 250 MHz clock
   always #2 clk = ~clk;

   // Compare and count
   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task final_report;
      $display("checks=%0d mismatches=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   // One-cycle register write
   task wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   // One-cycle register read, data checked in the following cycle
   task rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 chk(reg_rdata & m, e);
   endtask : rd

   // Pulse a request set or withdraw to the peripheral
   task go(input bit clr);
      @(posedge clk);
      if (clr) req_clr <= 1'b1;
      else req_set <= 1'b1;
      @(posedge clk);
      req_set <= 1'b0;
      req_clr <= 1'b0;
   endtask : go

   // Bounded wait for a strobe or an acknowledge
   task wait_ev(input bit ack);
      int n;
      n = 0;
      while ((ack ? per_ack : xfer_strobe) !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1 n++;
      end
      chk({31'h0, ack ? per_ack : xfer_strobe}, 32'h1);
   endtask : wait_ev

   // Bounded wait for a channel state
   task wait_st(input dmarpt_state_t s);
      int n;
      n = 0;
      while (chan_state !== s && n < 200) begin
         @(posedge clk);
         #1 n++;
      end
      chk({30'h0, chan_state}, {30'h0, s});
   endtask : wait_st

   // Count beats up to the acknowledge, or check silence for n cycles
   task beats(input int lim, input bit to_ack);
      int n;
      nb = 0;
      n  = 0;
      while (!(to_ack && per_ack === 1'b1) && n < lim) begin
         @(posedge clk);
         #1 n++;
         if (xfer_strobe !== 1'b0) nb++;
      end
   endtask : beats

   // Watchdog
   initial begin
      #(4 * 30000);
      fail_count++;
      final_report();
   end

   // Main sequence
   initial begin
      clk = 1'b0; resetn = 1'b0; ce = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 5'h00;
      reg_wdata = 32'h0; req_set = 1'b0; req_clr = 1'b0; stop_set = 1'b0; err_arm = 1'b0;
      fail_count = 0; cmp_count = 0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      rd(5'h1c, 32'h0, FULL);
      // Repeat setup: reloads, failure enable, two blocks of four
      wr(OFS_GLOBAL, 32'h80000000);
      wr(OFS_CFG_B, 32'h0000003d);
      wr(OFS_SRC, 32'h00000100);
      wr(OFS_DST, 32'h00000200);
      wr(OFS_CFG_A, 32'h80010003);
      wait_st(DR_WAIT);
      rd(OFS_GLOBAL, 32'h80000000, FULL);
      // Successful repeat transfer
      go(1'b0);
      wait_ev(1'b0);
      chk(xfer_src, 32'h00000100);
      chk(xfer_dst, 32'h00000200);
      beats(400, 1'b1);
      chk(nb, 7);
      chk(xfer_src, 32'h0000011c);
      wait_st(DR_WAIT);
      chk({31'h0, irq}, 32'h0);
      rd(OFS_CFG_B, 32'h0005003d, FULL);
      rd(OFS_CFG_A, 32'h80010003, FULL);
      rd(OFS_SRC, 32'h00000100, FULL);
      rd(OFS_DST, 32'h00000200, FULL);
      // Bus error on first beat; request stays up so the channel retries
      err_arm <= 1'b1;
      go(1'b0);
      wait_ev(1'b0);
      @(posedge clk) err_arm <= 1'b0;
      #1 chk({30'h0, chan_state}, {30'h0, DR_WAIT});
      chk({31'h0, irq}, 32'h1);
      wait_st(DR_XFER);
      #4 chk({31'h0, irq}, 32'h0);
      wait_ev(1'b1);
      rd(OFS_CFG_A, 32'h80010003, FULL);
      // Peripheral stop in mid-transfer
      go(1'b0);
      wait_ev(1'b0);
      @(posedge clk) stop_set <= 1'b1;
      wait_st(DR_WAIT);
      chk({31'h0, irq}, 32'h1);
      rd(OFS_CFG_B, 32'h0002003d, FULL);
      rd(OFS_SRC, 32'h00000100, FULL);
      rd(OFS_CFG_A, 32'h80010003, FULL);
      beats(20, 1'b0);
      chk(nb, 0);
      @(posedge clk) stop_set <= 1'b0;
      beats(20, 1'b0);
      chk(nb, 0);
      chk({31'h0, irq}, 32'h1);
      go(1'b1);
      wr(OFS_CFG_B, 32'h0000003d);
      #1 chk({31'h0, irq}, 32'h0);
      wr(OFS_CFG_A, 32'h00010003);
      wait_st(DR_DISABLE);
      rd(OFS_CFG_B, 32'h0000003d, FULL);
      // Global disable in mid-transfer keeps channel enable
      wr(OFS_CFG_A, 32'h80010003);
      wait_st(DR_WAIT);
      go(1'b0);
      wait_ev(1'b0);
      wr(OFS_GLOBAL, 32'h00000000);
      wait_st(DR_DISABLE);
      chk({31'h0, irq}, 32'h1);
      rd(OFS_CFG_A, 32'h80000000, 32'h80000000);
      repeat (10) @(posedge clk);
      #1 chk({31'h0, irq}, 32'h1);
      rd(OFS_CFG_B, 32'h0002003d, FULL);
      go(1'b1);
      wr(OFS_CFG_B, 32'h0000003d);
      // Channel disable in mid-transfer
      wr(OFS_GLOBAL, 32'h80000000);
      wait_st(DR_WAIT);
      go(1'b0);
      wait_ev(1'b0);
      wr(OFS_CFG_A, 32'h00010003);
      wait_st(DR_DISABLE);
      chk({31'h0, irq}, 32'h1);
      rd(OFS_CFG_A, 32'h00000000, 32'h80000000);
      go(1'b1);
      wr(OFS_CFG_B, 32'h0000003d);
      // Global halt pauses and resumes
      wr(OFS_CFG_A, 32'h80010003);
      wait_st(DR_WAIT);
      go(1'b0);
      wait_ev(1'b0);
      wr(OFS_GLOBAL, 32'h81000000);
      wait_st(DR_PAUSE);
      beats(10, 1'b0);
      chk(nb, 0);
      wr(OFS_GLOBAL, 32'h80000000);
      wait_st(DR_XFER);
      wait_ev(1'b1);
      // Clear mask dropped mid-run ends in disable
      go(1'b0);
      wait_ev(1'b0);
      wr(OFS_CFG_B, 32'h0000003c);
      wait_ev(1'b1);
      wait_st(DR_DISABLE);
      chk({31'h0, irq}, 32'h0);
      rd(OFS_CFG_A, 32'h00010003, FULL);
      rd(OFS_CFG_B, 32'h0005003c, FULL);
      final_report();
   end
endmodule : tb_dma_channel_repeat_hw_transfer
`default_nettype wire
